// file: hw/gpc_port.sv
// Converter control port: three open-drain pins, converter arbitration and an APB register file.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/10ps

// Function
// - A converter runs when the register or the pin command enables it.
// - Standby only when both register and pin command ask for standby.
// - Synchronised levels of the three pins read back in standby register bits 5-7.
// - Pin 3 as output: released for output bit high, driven low otherwise.
// - Pins 1 and 2 as output: released for bit high, pulled low otherwise.
// - Pin 3 input with trigger enabled starts a conversion on the selected edge.
// - Pin 2 in interrupt mode pulls the host interrupt low on its selected edge.
// - Pin 1 interrupt mode: falling edge when polarity high, rising when low.
// - Pin 2 in enable mode turns converter B on while level matches polarity.
// - Pin 1 in enable mode turns converter A on while level matches polarity.
// - Pin 1 in standby mode requests standby while level matches polarity.
// - After reset pin 3 is an input with no function selected.
// - After reset pin 2 is an input enabling converter B while high.
// - Outside undervoltage and output mode, a pin interrupt releases only after two edges and a following bus read.
// - Undervoltage or switching a pin to output drops its pending interrupt.
// - After reset pin 1 is an input enabling converter A while high.
module gpc_port
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpc_pkg::GPC_ADDR_W-1:0] paddr,
    input wire logic [gpc_pkg::GPC_DATA_W-1:0] pwdata,
    output logic [gpc_pkg::GPC_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [gpc_pkg::GPC_NUM_PINS-1:0] pin_in,
    output logic [gpc_pkg::GPC_NUM_PINS-1:0] pin_out,
    output logic [gpc_pkg::GPC_NUM_PINS-1:0] pin_oe,
    input wire logic uvlo_in,
    output logic buck_a_en,
    output logic buck_b_en,
    output logic buck_standby,
    output logic conv_start,
    output logic host_int_n,
    output logic irq
);
    import gpc_pkg::*;

    // Picks the rising or the falling edge; used for every edge-sensitive function.
    function automatic logic sel_edge(input logic rise, input logic fall, input logic pick_fall);
        sel_edge = pick_fall ? fall : rise;
    endfunction

    logic [GPC_PIN12_W-1:0] pin12_config_reg;
    logic [GPC_PIN3_W-1:0] pin3_config_reg;
    logic buck_standby_reg;
    logic [1:0] buck_ctrl_reg;
    logic [GPC_IRQ_W-1:0] irq_status_reg;
    logic [GPC_IRQ_W-1:0] irq_mask_reg;
    logic [GPC_NUM_PINS:0] sync_meta_reg;
    logic [GPC_NUM_PINS:0] sync_reg;
    logic [GPC_NUM_PINS-1:0] pin_prev_reg;
    logic [GPC_DATA_W-1:0] rdata_next;
    logic addr_ok;
    logic wr_fire;
    logic rd_fire;
    logic [GPC_NUM_PINS-1:0] pin_sync;
    logic [GPC_NUM_PINS-1:0] rise;
    logic [GPC_NUM_PINS-1:0] fall;
    logic uvlo_sync;
    logic p1_dir, p1_out, p1_irq, p1_pol, p1_buck, p1_sby;
    logic p2_dir, p2_out, p2_irq, p2_pol, p2_buck;
    logic mode_irq1, mode_buck1, mode_sby1, mode_irq2, mode_buck2, mode_trig3;
    logic match1, match2;
    logic edge1, edge2, trig3;
    logic int1, int2;
    logic [GPC_IRQ_W-1:0] irq_set;
    logic [GPC_IRQ_W-1:0] irq_clr;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin and undervoltage synchronisers; the first stage feeds only the second.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            // Pins idle high on their pull-ups; starting low would fake an edge after reset.
            sync_meta_reg <= {1'b0, {GPC_NUM_PINS{1'b1}}};
            sync_reg <= {1'b0, {GPC_NUM_PINS{1'b1}}};
            pin_prev_reg <= '1;
        end
        else
        begin
            sync_meta_reg <= {uvlo_in, pin_in};
            sync_reg <= sync_meta_reg;
            pin_prev_reg <= sync_reg[GPC_NUM_PINS-1:0];
        end
    end

    assign pin_sync = sync_reg[GPC_NUM_PINS-1:0];
    assign uvlo_sync = sync_reg[GPC_NUM_PINS];
    assign rise = pin_sync & ~pin_prev_reg;
    assign fall = ~pin_sync & pin_prev_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin function decode.
    assign p1_dir = pin12_config_reg[GPC_P1_BASE+GPC_F_DIR];
    assign p1_out = pin12_config_reg[GPC_P1_BASE+GPC_F_OUT_VAL];
    assign p1_irq = pin12_config_reg[GPC_P1_BASE+GPC_F_IRQ_EN];
    assign p1_pol = pin12_config_reg[GPC_P1_BASE+GPC_F_POLARITY];
    assign p1_buck = pin12_config_reg[GPC_P1_BASE+GPC_F_BUCK_EN];
    assign p1_sby = pin12_config_reg[GPC_P1_BASE+GPC_F_STANDBY_EN];
    assign p2_dir = pin12_config_reg[GPC_P2_BASE+GPC_F_DIR];
    assign p2_out = pin12_config_reg[GPC_P2_BASE+GPC_F_OUT_VAL];
    assign p2_irq = pin12_config_reg[GPC_P2_BASE+GPC_F_IRQ_EN];
    assign p2_pol = pin12_config_reg[GPC_P2_BASE+GPC_F_POLARITY];
    assign p2_buck = pin12_config_reg[GPC_P2_BASE+GPC_F_BUCK_EN];

    // Pin 2 modes are decoded exclusively; setting both functions at once selects neither.
    assign mode_irq1 = !p1_dir && p1_irq && !p1_buck && !p1_sby;
    assign mode_buck1 = !p1_dir && !p1_irq && p1_buck && !p1_sby;
    assign mode_sby1 = !p1_dir && !p1_irq && !p1_buck && p1_sby;
    assign mode_irq2 = !p2_dir && p2_irq && !p2_buck;
    assign mode_buck2 = !p2_dir && !p2_irq && p2_buck;
    assign mode_trig3 = !pin3_config_reg[GPC_P3_DIR] && pin3_config_reg[GPC_P3_TRIG_EN];
    assign match1 = pin_sync[0] == p1_pol;
    assign match2 = pin_sync[1] == p2_pol;
    assign edge1 = mode_irq1 && sel_edge(rise[0], fall[0], p1_pol);
    assign edge2 = mode_irq2 && sel_edge(rise[1], fall[1], p2_pol);
    assign trig3 = mode_trig3 && sel_edge(rise[2], fall[2], !pin3_config_reg[GPC_P3_EDGE_SEL]);

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait-free access phase, answer registered in the setup cycle.
    assign addr_ok = paddr[1:0] == 2'h0 && (paddr == GPC_PIN12_CONFIG_OFS
        || paddr == GPC_PIN3_CONFIG_OFS || paddr == GPC_BUCK_STANDBY_OFS
        || paddr == GPC_BUCK_CTRL_OFS || paddr == GPC_IRQ_STATUS_OFS
        || paddr == GPC_IRQ_MASK_OFS);
    assign wr_fire = psel && penable && pready && pwrite && addr_ok;
    assign rd_fire = psel && penable && pready && !pwrite;

    always_comb
    begin
        rdata_next = '0;
        case (paddr)
            GPC_PIN12_CONFIG_OFS: rdata_next[GPC_PIN12_W-1:0] = pin12_config_reg;
            GPC_PIN3_CONFIG_OFS: rdata_next[GPC_PIN3_W-1:0] = pin3_config_reg;
            GPC_BUCK_STANDBY_OFS:
            begin
                rdata_next[GPC_SBY_CMD] = buck_standby_reg;
                rdata_next[GPC_SBY_PIN_LSB+:GPC_NUM_PINS] = pin_sync;
            end
            GPC_BUCK_CTRL_OFS: rdata_next[1:0] = buck_ctrl_reg;
            GPC_IRQ_STATUS_OFS: rdata_next[GPC_IRQ_W-1:0] = irq_status_reg;
            GPC_IRQ_MASK_OFS: rdata_next[GPC_IRQ_W-1:0] = irq_mask_reg;
            default: rdata_next = '0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= psel && !penable && !pready;
            pslverr <= psel && !penable && !pready && !addr_ok;
            if (psel && !penable && !pready)
            begin
                prdata <= pwrite ? '0 : rdata_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pin12_config_reg <= GPC_PIN12_RST;
            pin3_config_reg <= GPC_PIN3_RST;
            buck_standby_reg <= GPC_SBY_RST;
            buck_ctrl_reg <= GPC_CTRL_RST;
            irq_mask_reg <= GPC_IRQ_MASK_RST;
        end
        else if (wr_fire)
        begin
            case (paddr)
                GPC_PIN12_CONFIG_OFS:
                    pin12_config_reg <= pwdata[GPC_PIN12_W-1:0] & GPC_PIN12_WMASK;
                GPC_PIN3_CONFIG_OFS: pin3_config_reg <= pwdata[GPC_PIN3_W-1:0];
                GPC_BUCK_STANDBY_OFS: buck_standby_reg <= pwdata[GPC_SBY_CMD];
                GPC_BUCK_CTRL_OFS: buck_ctrl_reg <= pwdata[1:0];
                GPC_IRQ_MASK_OFS: irq_mask_reg <= pwdata[GPC_IRQ_W-1:0];
                default: buck_ctrl_reg <= buck_ctrl_reg;
            endcase
        end
    end

    // Only bits that were returned are cleared, so an event in the clearing cycle survives.
    assign irq_set = {trig3, edge2, edge1};
    assign irq_clr = (rd_fire && paddr == GPC_IRQ_STATUS_OFS) ? prdata[GPC_IRQ_W-1:0] : '0;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_status_reg <= '0;
            irq <= 1'b0;
        end
        else
        begin
            irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin interrupt latches and the shared active-low host line.
    gpc_irq_cell u_cell1
    (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .edge_evt(edge1),
        .bus_read(rd_fire),
        .release_now(uvlo_sync || p1_dir),
        .int_active(int1)
    );

    gpc_irq_cell u_cell2
    (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .edge_evt(edge2),
        .bus_read(rd_fire),
        .release_now(uvlo_sync || p2_dir),
        .int_active(int2)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers, converter arbitration and conversion trigger, all registered.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_out <= '0;
            pin_oe <= '0;
            buck_a_en <= 1'b0;
            buck_b_en <= 1'b0;
            buck_standby <= 1'b0;
            conv_start <= 1'b0;
            host_int_n <= 1'b1;
        end
        else
        begin
            pin_out <= '0;
            pin_oe[0] <= p1_dir && !p1_out;
            pin_oe[1] <= p2_dir && !p2_out;
            pin_oe[2] <= pin3_config_reg[GPC_P3_DIR] && !pin3_config_reg[GPC_P3_OUT_VAL];
            buck_a_en <= buck_ctrl_reg[GPC_CTRL_BUCK_A] || (mode_buck1 && match1);
            buck_b_en <= buck_ctrl_reg[GPC_CTRL_BUCK_B] || (mode_buck2 && match2);
            buck_standby <= buck_standby_reg && mode_sby1 && match1;
            conv_start <= trig3;
            host_int_n <= !(int1 || int2);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    logic seen_reset_reg;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            seen_reset_reg <= 1'b0;
        end
        else
        begin
            seen_reset_reg <= 1'b1;
        end
    end

    property p_reg_enable_wins;
        @(posedge clk_sys) disable iff (!rstn)
        buck_ctrl_reg[GPC_CTRL_BUCK_A] |=> buck_a_en;
    endproperty
    a_reg_enable_wins: assert property (p_reg_enable_wins)
        else $error("converter A off although the register enables it");

    property p_standby_needs_both;
        @(posedge clk_sys) disable iff (!rstn)
        !buck_standby_reg || !mode_sby1 || !match1 |=> !buck_standby;
    endproperty
    a_standby_needs_both: assert property (p_standby_needs_both)
        else $error("standby set without both commands");

    property p_level_readback;
        @(posedge clk_sys) disable iff (!rstn)
        psel && !penable && !pready && !pwrite && paddr == GPC_BUCK_STANDBY_OFS
        |=> prdata[GPC_SBY_PIN_LSB+:GPC_NUM_PINS] == $past(pin_sync) && pready;
    endproperty
    a_level_readback: assert property (p_level_readback)
        else $error("pin levels not returned in the standby register");

    property p_pin3_drive;
        @(posedge clk_sys) disable iff (!rstn)
        pin3_config_reg[GPC_P3_DIR] ##1 pin3_config_reg[GPC_P3_DIR]
        |-> pin_oe[2] == !$past(pin3_config_reg[GPC_P3_OUT_VAL]);
    endproperty
    a_pin3_drive: assert property (p_pin3_drive)
        else $error("pin 3 output level wrong");

    property p_pin12_release_on_input;
        @(posedge clk_sys) disable iff (!rstn)
        !p1_dir && !p2_dir |=> pin_oe[1:0] == 2'h0 && pin_out == '0;
    endproperty
    a_pin12_release_on_input: assert property (p_pin12_release_on_input)
        else $error("input pin driven");

    property p_trigger_edge;
        @(posedge clk_sys) disable iff (!rstn)
        mode_trig3 && pin3_config_reg[GPC_P3_EDGE_SEL] && rise[2] |=> conv_start ##1 !conv_start || trig3;
    endproperty
    a_trigger_edge: assert property (p_trigger_edge)
        else $error("rising edge did not start a conversion");

    property p_host_int_on_edge;
        @(posedge clk_sys) disable iff (!rstn)
        (edge1 || edge2) && !uvlo_sync && !p1_dir && !p2_dir |=> ##1 !host_int_n;
    endproperty
    a_host_int_on_edge: assert property (p_host_int_on_edge)
        else $error("host interrupt not asserted after a selected edge");

    property p_pin_b_level;
        @(posedge clk_sys) disable iff (!rstn)
        mode_buck2 && match2 |=> buck_b_en;
    endproperty
    a_pin_b_level: assert property (p_pin_b_level)
        else $error("converter B off although pin 2 enables it");

    property p_pin_a_off;
        @(posedge clk_sys) disable iff (!rstn)
        !buck_ctrl_reg[GPC_CTRL_BUCK_A] && !(mode_buck1 && match1) |=> !buck_a_en;
    endproperty
    a_pin_a_off: assert property (p_pin_a_off)
        else $error("converter A on with neither command");

    property p_reset_config;
        @(posedge clk_sys) disable iff (!rstn)
        !seen_reset_reg |-> pin12_config_reg == GPC_PIN12_RST && pin3_config_reg == GPC_PIN3_RST;
    endproperty
    a_reset_config: assert property (p_reset_config)
        else $error("pin configuration wrong after reset");

    property p_status_set_wins;
        @(posedge clk_sys) disable iff (!rstn)
        edge1 |=> irq_status_reg[GPC_IRQ_PIN1];
    endproperty
    a_status_set_wins: assert property (p_status_set_wins)
        else $error("pin 1 edge lost in the status register");

endmodule

// file: hw/gpc_pkg.sv
// Constants for the converter control port: register map, field layout and reset values.
package gpc_pkg;

    localparam int GPC_ADDR_W = 8;
    localparam int GPC_DATA_W = 32;
    localparam int GPC_NUM_PINS = 3;
    localparam int GPC_SYNC_STAGES = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [7:0] GPC_PIN12_CONFIG_OFS = 8'h00;
    localparam logic [7:0] GPC_PIN3_CONFIG_OFS = 8'h04;
    localparam logic [7:0] GPC_BUCK_STANDBY_OFS = 8'h08;
    localparam logic [7:0] GPC_BUCK_CTRL_OFS = 8'h0c;
    localparam logic [7:0] GPC_IRQ_STATUS_OFS = 8'h10;
    localparam logic [7:0] GPC_IRQ_MASK_OFS = 8'h14;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin 1 and pin 2 configuration: pin 1 in the low byte, pin 2 from bit 8.
    localparam int GPC_P1_BASE = 0;
    localparam int GPC_P2_BASE = 8;
    localparam int GPC_F_DIR = 0;
    localparam int GPC_F_OUT_VAL = 1;
    localparam int GPC_F_IRQ_EN = 2;
    localparam int GPC_F_POLARITY = 3;
    localparam int GPC_F_BUCK_EN = 4;
    localparam int GPC_F_STANDBY_EN = 5;
    localparam int GPC_PIN12_W = 14;
    localparam logic [13:0] GPC_PIN12_RST = 14'h1818;
    localparam logic [13:0] GPC_PIN12_WMASK = 14'h1f3f;

    // Pin 3 configuration.
    localparam int GPC_P3_DIR = 0;
    localparam int GPC_P3_OUT_VAL = 1;
    localparam int GPC_P3_TRIG_EN = 2;
    localparam int GPC_P3_EDGE_SEL = 3;
    localparam int GPC_PIN3_W = 4;
    localparam logic [3:0] GPC_PIN3_RST = 4'h0;

    // Standby register: bit 0 is the register standby command, bits 5 to 7 the pin levels.
    localparam int GPC_SBY_CMD = 0;
    localparam int GPC_SBY_PIN_LSB = 5;
    localparam logic GPC_SBY_RST = 1'b0;

    // Converter enable register.
    localparam int GPC_CTRL_BUCK_A = 0;
    localparam int GPC_CTRL_BUCK_B = 1;
    localparam logic [1:0] GPC_CTRL_RST = 2'h0;

    // Interrupt status and mask layout.
    localparam int GPC_IRQ_PIN1 = 0;
    localparam int GPC_IRQ_PIN2 = 1;
    localparam int GPC_IRQ_CONV = 2;
    localparam int GPC_IRQ_W = 3;
    localparam logic [2:0] GPC_IRQ_MASK_RST = 3'h0;

endpackage

// file: hw/gpc_irq_cell.sv
// Latched pin interrupt cell: a bus read releases it only after two edges; release_now clears it at once.
`timescale 1ns/10ps

module gpc_irq_cell
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic edge_evt,
    input wire logic bus_read,
    input wire logic release_now,
    output logic int_active
);

    logic armed_reg;

    // The first edge latches the request; only a second edge arms the read release.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            int_active <= 1'b0;
            armed_reg <= 1'b0;
        end
        else if (release_now)
        begin
            int_active <= 1'b0;
            armed_reg <= 1'b0;
        end
        else if (edge_evt)
        begin
            int_active <= 1'b1;
            armed_reg <= int_active;
        end
        else if (bus_read && armed_reg)
        begin
            int_active <= 1'b0;
            armed_reg <= 1'b0;
        end
    end

    property p_read_needs_second_edge;
        @(posedge clk_sys) disable iff (!rstn)
        int_active && !armed_reg && bus_read && !release_now && !edge_evt |=> int_active;
    endproperty
    a_read_needs_second_edge: assert property (p_read_needs_second_edge)
        else $error("interrupt released without a second pin edge");

    property p_release_clears;
        @(posedge clk_sys) disable iff (!rstn)
        release_now |=> !int_active ##1 ($past(edge_evt) || !int_active);
    endproperty
    a_release_clears: assert property (p_release_clears)
        else $error("interrupt still pending after release");

endmodule

// file: sim/gpc_pin_model.sv
// Board-side model of the three open-drain pins: pull-ups plus external drivers.
`timescale 1ns/10ps

module gpc_pin_model
(
    input wire logic [gpc_pkg::GPC_NUM_PINS-1:0] pin_oe,
    input wire logic [gpc_pkg::GPC_NUM_PINS-1:0] ext_low,
    output logic [gpc_pkg::GPC_NUM_PINS-1:0] pin_in
);
    import gpc_pkg::*;

    // The pull-up wins unless the device or an external part pulls the line low.
    assign pin_in = ~(pin_oe | ext_low);
endmodule

// file: sim/gpc_port_tb.sv
// Self-checking testbench for the converter control port over APB and its pins.
`timescale 1ns/10ps

module gpc_port_tb;
    import gpc_pkg::*;

    localparam logic [31:0] BUCK_MODE = (32'h1 << GPC_F_POLARITY) | (32'h1 << GPC_F_BUCK_EN);
    localparam logic [31:0] P12_RST = BUCK_MODE | (BUCK_MODE << GPC_P2_BASE);

    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] pin_in;
    logic [2:0] pin_oe;
    logic [2:0] pin_out;
    logic [2:0] ext_low = 3'h0;
    logic uvlo_in = 1'b0;
    logic buck_a_en;
    logic buck_b_en;
    logic buck_standby;
    logic conv_start;
    logic host_int_n;
    logic irq;
    logic [31:0] rdat;
    logic rerr;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int conv_cnt = 0;
    int n0;

    gpc_pin_model PINS (.pin_oe(pin_oe), .ext_low(ext_low), .pin_in(pin_in));

    gpc_port DUT (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .uvlo_in(uvlo_in),
        .buck_a_en(buck_a_en), .buck_b_en(buck_b_en), .buck_standby(buck_standby),
        .conv_start(conv_start), .host_int_n(host_int_n), .irq(irq));

    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cyc++;
        if (conv_start === 1'b1)
            conv_cnt++;
        if (cyc == 4000)
        begin
            err_total++;
            wrap_up;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask

    // The request is held until pready is sampled high; data is taken at that same edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
        chk(32'(rerr), 32'(er));
    endtask

    // Pin changes need two sync stages, edge logic and output flops before they show.
    task automatic settle;
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        settle;
        rd(GPC_PIN12_CONFIG_OFS, P12_RST, 1'b0);
        rd(GPC_PIN3_CONFIG_OFS, 32'h0, 1'b0);
        rd(GPC_BUCK_CTRL_OFS, 32'h0, 1'b0);
        rd(GPC_IRQ_MASK_OFS, 32'h0, 1'b0);
        rd(8'h18, 32'h0, 1'b1);
        chk(32'(buck_a_en), 1);
        chk(32'(buck_b_en), 1);
        chk(32'(pin_oe), 0);
        ext_low <= 3'h5;
        settle;
        rd(GPC_BUCK_STANDBY_OFS, 32'h2 << GPC_SBY_PIN_LSB, 1'b0);
        chk(32'(buck_a_en), 0);
        chk(32'(buck_b_en), 1);
        ext_low <= 3'h7;
        wr(GPC_BUCK_CTRL_OFS, 32'h1);
        settle;
        chk(32'(buck_a_en), 1);
        chk(32'(buck_b_en), 0);
        ext_low <= 3'h0;
        wr(GPC_BUCK_CTRL_OFS, 32'h0);
        wr(GPC_PIN12_CONFIG_OFS, 32'h28 | (BUCK_MODE << GPC_P2_BASE));
        settle;
        chk(32'(buck_standby), 0);
        wr(GPC_BUCK_STANDBY_OFS, 32'h1);
        settle;
        chk(32'(buck_standby), 1);
        chk(32'(buck_a_en), 0);
        ext_low <= 3'h1;
        settle;
        chk(32'(buck_standby), 0);
        ext_low <= 3'h0;
        wr(GPC_BUCK_STANDBY_OFS, 32'h0);
        for (int k = 0; k < 2; k++)
        begin
            wr(GPC_PIN12_CONFIG_OFS, k ? 32'h303 : 32'h101);
            wr(GPC_PIN3_CONFIG_OFS, k ? 32'h3 : 32'h1);
            settle;
            chk(32'(pin_oe), k ? 0 : 7);
            chk(32'(pin_out), 0);
        end
        for (int p = 0; p < 2; p++)
        begin
            wr(GPC_PIN12_CONFIG_OFS, 32'hc << (p ? GPC_P2_BASE : GPC_P1_BASE));
            wr(GPC_IRQ_MASK_OFS, 32'h3);
            ext_low[p] <= 1'b1;
            settle;
            chk(32'(host_int_n), 0);
            chk(32'(irq), 1);
            rd(GPC_IRQ_STATUS_OFS, 32'h1 << p, 1'b0);
            settle;
            chk(32'(host_int_n), 0);
            chk(32'(irq), 0);
            ext_low[p] <= 1'b0;
            settle;
            ext_low[p] <= 1'b1;
            settle;
            chk(32'(host_int_n), 0);
            rd(GPC_IRQ_STATUS_OFS, 32'h1 << p, 1'b0);
            settle;
            chk(32'(host_int_n), 1);
            ext_low[p] <= 1'b0;
            settle;
        end
        for (int e = 0; e < 2; e++)
        begin
            wr(GPC_PIN3_CONFIG_OFS, 32'h4 | (32'(e) << GPC_P3_EDGE_SEL));
            n0 = conv_cnt;
            ext_low[2] <= 1'b1;
            settle;
            chk(32'(conv_cnt - n0), e ? 0 : 1);
            ext_low[2] <= 1'b0;
            settle;
            chk(32'(conv_cnt - n0), 1);
        end
        wr(GPC_IRQ_MASK_OFS, 32'h0);
        wr(GPC_PIN12_CONFIG_OFS, 32'h4);
        ext_low[0] <= 1'b1;
        settle;
        chk(32'(host_int_n), 1);
        ext_low[0] <= 1'b0;
        settle;
        chk(32'(host_int_n), 0);
        chk(32'(irq), 0);
        uvlo_in <= 1'b1;
        settle;
        chk(32'(host_int_n), 1);
        uvlo_in <= 1'b0;
        ext_low[0] <= 1'b1;
        settle;
        ext_low[0] <= 1'b0;
        settle;
        chk(32'(host_int_n), 0);
        wr(GPC_PIN12_CONFIG_OFS, 32'h3);
        settle;
        chk(32'(host_int_n), 1);
        wrap_up;
    end
endmodule
